// *** src/clock_noise_map.svh ***
// Register offsets, field positions and reset values of the clock block.
`ifndef CLOCK_NOISE_MAP_SVH
`define CLOCK_NOISE_MAP_SVH

// ====================================================================
// Register offsets
`define ADDR_SYS_CLOCK_CTRL_A   8'he0
`define ADDR_SYS_CLOCK_CTRL_B   8'he1
`define ADDR_SYS_CLOCK_CTRL_C   8'he2
`define ADDR_NOISE_REDUCTION    8'he3
`define ADDR_PROTECTION_KEY     8'he4
`define ADDR_DOUBLER_CTRL_A     8'he8
`define ADDR_DOUBLER_CTRL_B     8'he9

// ====================================================================
// System clock control fields and reset values
`define SCC_A_HF_OSC_ENABLE     7
`define SCC_A_PRESCALER_HI      1
`define SCC_A_PRESCALER_LO      0
`define SCC_A_RESET             8'h80
`define SCC_B_RESET             8'h04
`define SCC_B_READ_MASK         8'h0f
`define SCC_C_RESET             8'h00
`define SCC_C_READ_MASK         8'h7d

// ====================================================================
// Noise reduction fields, key and reset values
`define NRC_PROTECT             7
`define NRC_LATCH_STROBE_EN     3
`define NRC_EXT_CLOCK_IN        2
`define NRC_HF_DRIVE_NORMAL     1
`define NRC_LF_DRIVE_NORMAL     0
`define NRC_LATCH_STROBE_RESET  1'h0
`define NRC_EXT_CLOCK_RESET     1'h0
`define NRC_DRIVE_RESET         1'h1
`define PROTECT_RESET           1'h0
`define PROTECTION_KEY_VALUE    8'h1f
`define DOUBLER_A_RESET         8'h00
`define DOUBLER_A_READ_MASK     8'hdf
`define DOUBLER_B_RESET         8'h00

`endif

// *** src/clock_noise_pkg.sv ***
// Types shared by the clock and noise reduction register block.
package clock_noise_pkg;
   typedef logic [7:0] addr_type;
   typedef logic [7:0] byte_type;
   typedef logic [1:0] prescaler_type;
endpackage

// *** src/reg_port_if.sv ***
// Internal register port between the decoder and the clock registers.
`timescale 1ns/1ps
`default_nettype none
interface reg_port_if;
   logic                     wr;
   clock_noise_pkg::addr_type addr;
   clock_noise_pkg::byte_type wdata;
   clock_noise_pkg::byte_type rdata;
   modport host (output wr, output addr, output wdata, input rdata);
   modport regs (input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// *** src/sys_clock_regs.sv ***
// System clock control registers a, b and c.
`timescale 1ns/1ps
`default_nettype none
`include "clock_noise_map.svh"
module sys_clock_regs
(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   // Register port
   reg_port_if.regs                    bus,
   // Clock controls
   output logic                        hf_osc_enable,
   output clock_noise_pkg::prescaler_type prescaler_source_sel
);
   import clock_noise_pkg::*;

   byte_type ctrl_a;
   byte_type ctrl_b;
   byte_type ctrl_c;

   // ==================================================================
   // Register storage
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_a <= `SCC_A_RESET;
         ctrl_b <= `SCC_B_RESET;
         ctrl_c <= `SCC_C_RESET;
      end
      else if (bus.wr)
      begin
         if (bus.addr == `ADDR_SYS_CLOCK_CTRL_A)
            ctrl_a <= bus.wdata;
         if (bus.addr == `ADDR_SYS_CLOCK_CTRL_B)
            ctrl_b <= bus.wdata & `SCC_B_READ_MASK;
         if (bus.addr == `ADDR_SYS_CLOCK_CTRL_C)
            ctrl_c <= bus.wdata & `SCC_C_READ_MASK;
      end
   end

   // ==================================================================
   // Read mux; bits without storage read as zero.
   always_comb
   begin
      unique case (bus.addr)
         `ADDR_SYS_CLOCK_CTRL_A: bus.rdata = ctrl_a;
         `ADDR_SYS_CLOCK_CTRL_B: bus.rdata = ctrl_b & `SCC_B_READ_MASK;
         `ADDR_SYS_CLOCK_CTRL_C: bus.rdata = ctrl_c & `SCC_C_READ_MASK;
         default:                bus.rdata = 8'h00;
      endcase
   end

   assign hf_osc_enable        = ctrl_a[`SCC_A_HF_OSC_ENABLE];
   assign prescaler_source_sel =
      ctrl_a[`SCC_A_PRESCALER_HI:`SCC_A_PRESCALER_LO];

   // ==================================================================
   // Checks
   AST_CTRL_B_UPPER_ZERO: assert property (
      @(posedge clk) disable iff (!arst_n)
      (bus.addr == `ADDR_SYS_CLOCK_CTRL_B) |-> (bus.rdata[7:4] == 4'h0))
      else $error("Upper bits of control b read nonzero.");
   AST_CTRL_C_MASKED_ZERO: assert property (
      @(posedge clk) disable iff (!arst_n)
      (bus.addr == `ADDR_SYS_CLOCK_CTRL_C)
      |-> (bus.rdata[7] == 1'b0 && bus.rdata[1] == 1'b0))
      else $error("Masked bits of control c read nonzero.");
endmodule // sys_clock_regs
`default_nettype wire

// *** src/clock_noise_control_regs.sv ***
// Clock and noise reduction control registers with their outputs.
`timescale 1ns/1ps
`default_nettype none
`include "clock_noise_map.svh"

// Notes on behaviour
// - Oscillator enable bit stops or runs oscillator.
// - Undefined control bits read zero, except in control a; software ignores.
// - Key 1fh written turns protection off.
// - Any other key value turns protection on.
// - Protect flag reads protection state, read only.
// - Latch strobe output enable gates strobe pulses.
// - Drive bits: one normal, zero weak.
// - External clock bit disables oscillator, forces pin.
// - Reset sets both drive bits to normal.
module clock_noise_control_regs
(
   // Clock and reset
   input  wire logic                       SYS_CLK,
   input  wire logic                       ARST_N,
   // Register port
   input  wire clock_noise_pkg::addr_type  ADDR,
   input  wire clock_noise_pkg::byte_type  WDATA,
   input  wire logic                       WR,
   input  wire logic                       RD,
   output clock_noise_pkg::byte_type       RDATA,
   // External bus strobe
   input  wire logic                       ALE_REQ,
   output logic                            ALE_OUT,
   // Oscillator controls
   output logic                            HF_OSC_RUN,
   output logic                            HF_OSC_BUFFER_MODE,
   output logic                            OSC2_FORCE_HIGH,
   output logic                            HF_DRIVE_NORMAL,
   output logic                            LF_DRIVE_NORMAL,
   output clock_noise_pkg::prescaler_type  PRESCALER_SOURCE_SEL,
   // Protection state
   output logic                            PROTECT_ON
);
   import clock_noise_pkg::*;

   logic     hf_osc_enable;
   logic     latch_strobe_out_en;
   logic     ext_clock_in_sel;
   byte_type doubler_a;
   byte_type doubler_b;
   byte_type next_rdata;
   reg_port_if sys_port ();

   // ==================================================================
   // System clock control registers
   assign sys_port.wr    = WR;
   assign sys_port.addr  = ADDR;
   assign sys_port.wdata = WDATA;

   sys_clock_regs u_sys_clock_regs
   (
      .clk                  (SYS_CLK),
      .arst_n               (ARST_N),
      .bus                  (sys_port.regs),
      .hf_osc_enable        (hf_osc_enable),
      .prescaler_source_sel (PRESCALER_SOURCE_SEL)
   );

   // ==================================================================
   // Noise reduction register
   always_ff @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         latch_strobe_out_en <= `NRC_LATCH_STROBE_RESET;
         ext_clock_in_sel    <= `NRC_EXT_CLOCK_RESET;
         HF_DRIVE_NORMAL     <= `NRC_DRIVE_RESET;
         LF_DRIVE_NORMAL     <= `NRC_DRIVE_RESET;
      end
      else if (WR && ADDR == `ADDR_NOISE_REDUCTION)
      begin
         latch_strobe_out_en <= WDATA[`NRC_LATCH_STROBE_EN];
         ext_clock_in_sel    <= WDATA[`NRC_EXT_CLOCK_IN];
         HF_DRIVE_NORMAL     <= WDATA[`NRC_HF_DRIVE_NORMAL];
         LF_DRIVE_NORMAL     <= WDATA[`NRC_LF_DRIVE_NORMAL];
      end
   end

   // ==================================================================
   // Protection key
   always_ff @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         PROTECT_ON <= `PROTECT_RESET;
      else if (WR && ADDR == `ADDR_PROTECTION_KEY)
         PROTECT_ON <= (WDATA != `PROTECTION_KEY_VALUE);
   end

   // ==================================================================
   // Doubler registers, kept as plain storage.
   always_ff @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         doubler_a <= `DOUBLER_A_RESET;
         doubler_b <= `DOUBLER_B_RESET;
      end
      else if (WR)
      begin
         if (ADDR == `ADDR_DOUBLER_CTRL_A)
            doubler_a <= WDATA & `DOUBLER_A_READ_MASK;
         if (ADDR == `ADDR_DOUBLER_CTRL_B)
            doubler_b <= WDATA;
      end
   end

   // ==================================================================
   // Read path; data stand only in the cycle after the read strobe.
   always_comb
   begin
      unique case (ADDR)
         `ADDR_SYS_CLOCK_CTRL_A,
         `ADDR_SYS_CLOCK_CTRL_B,
         `ADDR_SYS_CLOCK_CTRL_C: next_rdata = sys_port.rdata;
         `ADDR_NOISE_REDUCTION:  next_rdata =
            {PROTECT_ON, 3'h0, latch_strobe_out_en, ext_clock_in_sel,
             HF_DRIVE_NORMAL, LF_DRIVE_NORMAL};
         `ADDR_DOUBLER_CTRL_A:   next_rdata = doubler_a;
         `ADDR_DOUBLER_CTRL_B:   next_rdata = doubler_b;
         default:                next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         RDATA <= 8'h00;
      else if (RD)
         RDATA <= next_rdata;
      else
         RDATA <= 8'h00;
   end

   // ==================================================================
   // Latch strobe gating
   always_ff @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         ALE_OUT <= 1'b0;
      else
         ALE_OUT <= ALE_REQ & latch_strobe_out_en;
   end

   // ==================================================================
   // Oscillator control outputs
   assign HF_OSC_RUN         = hf_osc_enable & ~ext_clock_in_sel;
   assign HF_OSC_BUFFER_MODE = ext_clock_in_sel;
   assign OSC2_FORCE_HIGH    = ext_clock_in_sel;

   // ==================================================================
   // Checks
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);

   AST_OSC_STOP_ON_CLEAR: assert property (
      WR && ADDR == `ADDR_SYS_CLOCK_CTRL_A && !WDATA[7] |=> !HF_OSC_RUN)
      else $error("Oscillator still runs after enable cleared.");
   AST_OSC_RUN_ON_SET: assert property (
      WR && ADDR == `ADDR_SYS_CLOCK_CTRL_A && WDATA[7]
      && !ext_clock_in_sel && !(WR && ADDR == `ADDR_NOISE_REDUCTION)
      |=> HF_OSC_RUN)
      else $error("Oscillator not running after enable set.");
   AST_CTRL_B_READ_UPPER: assert property (
      RD && ADDR == `ADDR_SYS_CLOCK_CTRL_B |=> RDATA[7:4] == 4'h0)
      else $error("Control b upper bits read nonzero.");
   AST_KEY_UNLOCK: assert property (
      WR && ADDR == `ADDR_PROTECTION_KEY && WDATA == 8'h1f
      |=> !PROTECT_ON)
      else $error("Key did not turn protection off.");
   AST_KEY_LOCK: assert property (
      WR && ADDR == `ADDR_PROTECTION_KEY && WDATA != 8'h1f
      |=> PROTECT_ON)
      else $error("Wrong key did not turn protection on.");
   AST_PROTECT_READBACK: assert property (
      RD && ADDR == `ADDR_NOISE_REDUCTION |=> RDATA[7] == $past(PROTECT_ON))
      else $error("Protect flag read back wrong.");
   AST_STROBE_GATED: assert property (
      ALE_REQ && !latch_strobe_out_en |=> !ALE_OUT)
      else $error("Strobe passed while disabled.");
   AST_STROBE_PASSED: assert property (
      ALE_REQ && latch_strobe_out_en |=> ALE_OUT)
      else $error("Strobe lost while enabled.");
   AST_WEAK_DRIVE: assert property (
      WR && ADDR == `ADDR_NOISE_REDUCTION && !WDATA[1] && !WDATA[0]
      |=> !HF_DRIVE_NORMAL && !LF_DRIVE_NORMAL)
      else $error("Drive bits not weak after clear.");
   AST_EXT_CLOCK: assert property (
      WR && ADDR == `ADDR_NOISE_REDUCTION && WDATA[2]
      |=> !HF_OSC_RUN && OSC2_FORCE_HIGH && HF_OSC_BUFFER_MODE)
      else $error("External clock select had no effect.");
   AST_DRIVE_AFTER_RESET: assert property (
      $rose(ARST_N) |-> HF_DRIVE_NORMAL && LF_DRIVE_NORMAL)
      else $error("Drive bits not normal after reset.");
   AST_EXT_CLEAR_AFTER_RESET: assert property (
      $rose(ARST_N) |-> !HF_OSC_BUFFER_MODE && !OSC2_FORCE_HIGH)
      else $error("External clock select set after reset.");
   AST_KEY_FULL_BYTE: assert property (
      WR && ADDR == `ADDR_PROTECTION_KEY && WDATA[4:0] == 5'h1f
      && WDATA[7:5] != 3'h0 |=> PROTECT_ON)
      else $error("Partial key match turned protection off.");
   AST_PROTECT_READ_ONLY: assert property (
      WR && ADDR == `ADDR_NOISE_REDUCTION
      |=> PROTECT_ON == $past(PROTECT_ON))
      else $error("Protect flag changed by noise register write.");

   COV_UNLOCK_THEN_LOCK: cover property (
      !PROTECT_ON ##[1:20] PROTECT_ON);
   COV_STROBE_OUT: cover property (ALE_OUT);
   COV_KEY_UNLOCK: cover property (
      WR && ADDR == `ADDR_PROTECTION_KEY && WDATA == `PROTECTION_KEY_VALUE);
   COV_EXT_CLOCK: cover property ($rose(OSC2_FORCE_HIGH));
endmodule // clock_noise_control_regs
`default_nettype wire

// *** verification/clock_noise_control_regs_tb_top.sv ***
// Self-checking testbench of the clock and noise reduction registers.
`timescale 1ns/1ps
`default_nettype none
`include "clock_noise_map.svh"
module clock_noise_control_regs_tb_top;
   import clock_noise_pkg::*;
   // =================================================================
   // Signals
   logic                 sys_clk;
   logic                 arst_n;
   addr_type             addr;
   byte_type             wdata;
   logic                 wr_strobe;
   logic                 rd_strobe;
   byte_type             rdata;
   logic                 ale_req;
   logic                 ale_out;
   logic                 hf_run;
   logic                 hf_buffer;
   logic                 osc2_high;
   logic                 hf_drive;
   logic                 lf_drive;
   prescaler_type        prescaler;
   logic                 protect_on;
   byte_type             osc_state;
   int                   miscompares;
   int                   checked;

   assign osc_state = {protect_on, prescaler, hf_run, hf_buffer, osc2_high,
                       hf_drive, lf_drive};

   // =================================================================
   // Design under test
   clock_noise_control_regs dut_u
   (
      .SYS_CLK              (sys_clk),
      .ARST_N               (arst_n),
      .ADDR                 (addr),
      .WDATA                (wdata),
      .WR                   (wr_strobe),
      .RD                   (rd_strobe),
      .RDATA                (rdata),
      .ALE_REQ              (ale_req),
      .ALE_OUT              (ale_out),
      .HF_OSC_RUN           (hf_run),
      .HF_OSC_BUFFER_MODE   (hf_buffer),
      .OSC2_FORCE_HIGH      (osc2_high),
      .HF_DRIVE_NORMAL      (hf_drive),
      .LF_DRIVE_NORMAL      (lf_drive),
      .PRESCALER_SOURCE_SEL (prescaler),
      .PROTECT_ON           (protect_on)
   );

   // =================================================================
   // Clock
   initial sys_clk = 1'b0;
   always #2 sys_clk = ~sys_clk;

   // =================================================================
   // Tasks
   task automatic chk(input byte_type seen, input byte_type exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input addr_type a, input byte_type d);
      @(posedge sys_clk);
      addr      <= a;
      wdata     <= d;
      wr_strobe <= 1'b1;
      @(posedge sys_clk);
      wr_strobe <= 1'b0;
      #1;
   endtask

   task automatic rd_reg(input addr_type a, input byte_type e);
      @(posedge sys_clk);
      addr      <= a;
      rd_strobe <= 1'b1;
      @(posedge sys_clk);
      rd_strobe <= 1'b0;
      #1;
      chk(rdata, e);
      @(posedge sys_clk);
      #1;
      chk(rdata, 8'h00);
   endtask

   task automatic ale_chk(input logic e);
      @(posedge sys_clk);
      ale_req <= 1'b1;
      @(posedge sys_clk);
      ale_req <= 1'b0;
      #1;
      chk({7'h00, ale_out}, {7'h00, e});
   endtask

   task automatic wrap_up;
      if (miscompares == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // =================================================================
   // Watchdog
   initial
   begin
      #20000;
      miscompares++;
      wrap_up();
   end

   // =================================================================
   // Tests
   initial
   begin
      miscompares = 0;
      checked     = 0;
      arst_n      = 1'b0;
      addr        = 8'h00;
      wdata       = 8'h00;
      wr_strobe   = 1'b0;
      rd_strobe   = 1'b0;
      ale_req     = 1'b0;
      repeat (8) @(posedge sys_clk);
      arst_n <= 1'b1;
      #1;
      chk(osc_state, 8'h13);
      rd_reg(`ADDR_NOISE_REDUCTION, 8'h03);
      rd_reg(`ADDR_SYS_CLOCK_CTRL_A, 8'h80);
      wr_reg(`ADDR_SYS_CLOCK_CTRL_A, 8'h00);
      chk(osc_state, 8'h03);
      wr_reg(`ADDR_SYS_CLOCK_CTRL_A, 8'h83);
      chk(osc_state, 8'h73);
      wr_reg(`ADDR_SYS_CLOCK_CTRL_A, 8'h80);
      chk(osc_state, 8'h13);
      wr_reg(`ADDR_SYS_CLOCK_CTRL_B, 8'hff);
      rd_reg(`ADDR_SYS_CLOCK_CTRL_B, 8'h0f);
      wr_reg(`ADDR_SYS_CLOCK_CTRL_C, 8'hff);
      rd_reg(`ADDR_SYS_CLOCK_CTRL_C, 8'h7d);
      wr_reg(`ADDR_NOISE_REDUCTION, 8'h04);
      chk(osc_state, 8'h0c);
      rd_reg(`ADDR_NOISE_REDUCTION, 8'h04);
      wr_reg(`ADDR_NOISE_REDUCTION, 8'h0a);
      chk(osc_state, 8'h12);
      rd_reg(`ADDR_NOISE_REDUCTION, 8'h0a);
      ale_chk(1'b1);
      wr_reg(`ADDR_NOISE_REDUCTION, 8'h01);
      chk(osc_state, 8'h11);
      ale_chk(1'b0);
      wr_reg(`ADDR_NOISE_REDUCTION, 8'h83);
      chk(osc_state, 8'h13);
      wr_reg(`ADDR_PROTECTION_KEY, 8'h9f);
      chk(osc_state, 8'h93);
      rd_reg(`ADDR_NOISE_REDUCTION, 8'h83);
      wr_reg(`ADDR_PROTECTION_KEY, `PROTECTION_KEY_VALUE);
      chk(osc_state, 8'h13);
      rd_reg(`ADDR_NOISE_REDUCTION, 8'h03);
      wr_reg(`ADDR_PROTECTION_KEY, 8'h00);
      chk(osc_state, 8'h93);
      wr_reg(`ADDR_PROTECTION_KEY, 8'h1e);
      chk(osc_state, 8'h93);
      rd_reg(`ADDR_PROTECTION_KEY, 8'h00);
      wr_reg(`ADDR_PROTECTION_KEY, `PROTECTION_KEY_VALUE);
      chk(osc_state, 8'h13);
      wr_reg(`ADDR_DOUBLER_CTRL_A, 8'hff);
      rd_reg(`ADDR_DOUBLER_CTRL_A, 8'hdf);
      wr_reg(8'he5, 8'hff);
      rd_reg(8'he5, 8'h00);
      wrap_up();
   end
endmodule // clock_noise_control_regs_tb_top
`default_nettype wire
